/* pkg/tccps_pkg.sv */
package tccps_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] TCCPS_CC_STATUS_OFS = 8'h1d;
    localparam logic [7:0] TCCPS_POWER_STATUS_OFS = 8'h1e;
    localparam logic [7:0] TCCPS_CC_STATUS_RESET = 8'h00;
    localparam logic [7:0] TCCPS_POWER_STATUS_RESET = 8'h08;
    localparam logic [7:0] TCCPS_READ_NONE = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int TCCPS_SEEK_BIT = 5;
    localparam int TCCPS_RES_BIT = 4;
    localparam int TCCPS_LINE_TWO_LSB = 2;
    localparam int TCCPS_LINE_ONE_LSB = 0;
    localparam int TCCPS_ACC_BIT = 7;
    localparam int TCCPS_INIT_BIT = 6;
    localparam int TCCPS_HV_BIT = 5;
    localparam int TCCPS_SRC_BIT = 4;
    localparam int TCCPS_DET_EN_BIT = 3;
    localparam int TCCPS_BUS_BIT = 2;
    localparam int TCCPS_CABLE_BIT = 1;
    localparam int TCCPS_SNK_BIT = 0;

    // ****************************************
    // Encodings
    // ****************************************
    typedef enum logic [1:0] {
        TCCPS_TERM_RA = 2'b00,
        TCCPS_TERM_RP = 2'b01,
        TCCPS_TERM_RD = 2'b10,
        TCCPS_TERM_OPEN = 2'b11
    } tccps_term_t;

    localparam logic [1:0] TCCPS_LINE_OPEN = 2'h0;
    localparam logic [1:0] TCCPS_SRC_RA = 2'h1;
    localparam logic [1:0] TCCPS_SRC_RD = 2'h2;
    localparam logic [1:0] TCCPS_SRC_RSVD = 2'h3;
    localparam logic [1:0] TCCPS_SNK_DEFAULT = 2'h1;
    localparam logic [1:0] TCCPS_SNK_1P5 = 2'h2;
    localparam logic [1:0] TCCPS_SNK_3P0 = 2'h3;

    typedef enum logic {
        TCCPS_DISCH_IDLE = 1'b0,
        TCCPS_DISCH_ACTIVE = 1'b1
    } tccps_disch_t;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        tccps_term_t cc1_term;
        tccps_term_t cc2_term;
        logic drp_mode;
        logic vconn_source_enable;
        logic plug_flip;
        logic seeking_connection;
        logic presenting_rd;
    } tccps_ctrl_t;

    typedef struct packed {
        logic accessory_attached;
        logic init_pending;
        logic high_voltage_sourcing;
        logic source_path_out;
        logic vbus_source_enable;
        logic presence_detect_enabled;
        logic sink_path_out;
    } tccps_power_t;

    typedef struct packed {
        logic [1:0] line_one_code;
        logic [1:0] line_two_code;
        logic bus_power_cmp;
        logic cable_power_cmp;
        logic below_safe0v_cmp;
    } tccps_sense_t;

    typedef struct packed {
        tccps_sense_t sense_meta;
        tccps_sense_t sense_sync;
        logic [7:0] cc_status;
        logic [7:0] power_status;
        logic resolved;
        logic seek_prev;
        tccps_disch_t disch;
        logic cc_irq;
        logic pwr_irq;
        logic [7:0] rd_data;
        logic rd_valid;
    } tccps_state_t;

    localparam tccps_state_t TCCPS_STATE_RESET = '{
        sense_meta: '0,
        sense_sync: '0,
        cc_status: TCCPS_CC_STATUS_RESET,
        power_status: TCCPS_POWER_STATUS_RESET,
        resolved: 1'b0,
        seek_prev: 1'b0,
        disch: TCCPS_DISCH_IDLE,
        cc_irq: 1'b0,
        pwr_irq: 1'b0,
        rd_data: TCCPS_READ_NONE,
        rd_valid: 1'b0
    };

endpackage

/* hw/tccps_status.sv */
module tccps_status (
    input wire logic sys_clk,
    input wire logic rst,
    input wire tccps_pkg::tccps_ctrl_t ctrl,
    input wire tccps_pkg::tccps_power_t power,
    input wire tccps_pkg::tccps_sense_t sense_pin,
    input wire logic discharge_start,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic [7:0] cc_line_status,
    output logic [7:0] power_path_status,
    output logic cc_change_irq,
    output logic power_change_irq,
    output logic discharge_active,
    output logic resolved_termination
);
    import tccps_pkg::*;

    tccps_state_t st_reg;
    tccps_state_t st_next;

    // ****************************************
    // Line field decode
    // ****************************************
    function automatic logic [1:0] line_code(
        input tccps_term_t term,
        input logic drp,
        input logic res,
        input logic [1:0] code
    );
        logic sink_view;
        logic [1:0] val;
        sink_view = drp ? res : (term == TCCPS_TERM_RD);
        if (!drp && (term == TCCPS_TERM_RA || term == TCCPS_TERM_OPEN)) begin
            val = TCCPS_LINE_OPEN;
        end else if (sink_view) begin
            val = code;
        end else if (code == TCCPS_SRC_RSVD) begin
            // Reserved source code never reaches software
            val = TCCPS_LINE_OPEN;
        end else begin
            val = code;
        end
        return val;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        // Comparators are asynchronous to sys_clk
        st_next.sense_meta = sense_pin;
        st_next.sense_sync = st_reg.sense_meta;

        st_next.seek_prev = ctrl.seeking_connection;
        // Latch the termination presented when the search stops, then hold it
        if (st_reg.seek_prev && !ctrl.seeking_connection) begin
            st_next.resolved = ctrl.presenting_rd;
        end

        st_next.cc_status = TCCPS_CC_STATUS_RESET;
        st_next.cc_status[TCCPS_SEEK_BIT] = ctrl.seeking_connection;
        st_next.cc_status[TCCPS_RES_BIT] = st_next.resolved;
        // Searching and the flip-0 VCONN case blank both fields; the swapped case does not
        if (!ctrl.seeking_connection && !(ctrl.vconn_source_enable && !ctrl.plug_flip)) begin
            st_next.cc_status[TCCPS_LINE_ONE_LSB +: 2] =
                line_code(ctrl.cc1_term, ctrl.drp_mode, st_next.resolved, st_reg.sense_sync.line_one_code);
            st_next.cc_status[TCCPS_LINE_TWO_LSB +: 2] =
                line_code(ctrl.cc2_term, ctrl.drp_mode, st_next.resolved, st_reg.sense_sync.line_two_code);
        end

        st_next.power_status[TCCPS_ACC_BIT] = power.accessory_attached;
        st_next.power_status[TCCPS_INIT_BIT] = power.init_pending;
        st_next.power_status[TCCPS_HV_BIT] = power.high_voltage_sourcing;
        st_next.power_status[TCCPS_SRC_BIT] = power.source_path_out && power.vbus_source_enable;
        st_next.power_status[TCCPS_DET_EN_BIT] = power.presence_detect_enabled;
        st_next.power_status[TCCPS_BUS_BIT] = st_reg.sense_sync.bus_power_cmp;
        st_next.power_status[TCCPS_CABLE_BIT] =
            st_reg.sense_sync.cable_power_cmp && ctrl.vconn_source_enable;
        st_next.power_status[TCCPS_SNK_BIT] = power.sink_path_out;

        // Alerts are one-cycle pulses; cc_irq and pwr_irq are recomputed every cycle, not latched
        st_next.cc_irq = (st_next.cc_status != st_reg.cc_status);
        st_next.pwr_irq = (st_next.power_status != st_reg.power_status);

        unique case (st_reg.disch)
            TCCPS_DISCH_IDLE: begin
                if (discharge_start && !st_reg.sense_sync.below_safe0v_cmp) begin
                    st_next.disch = TCCPS_DISCH_ACTIVE;
                end
            end
            TCCPS_DISCH_ACTIVE: begin
                if (st_reg.sense_sync.below_safe0v_cmp) begin
                    st_next.disch = TCCPS_DISCH_IDLE;
                end
            end
        endcase

        // Writes are dropped and reads do not touch the status
        st_next.rd_valid = reg_rd && !reg_wr;
        st_next.rd_data = TCCPS_READ_NONE;
        if (reg_rd && !reg_wr) begin
            if (reg_addr == TCCPS_CC_STATUS_OFS) begin
                st_next.rd_data = st_reg.cc_status;
            end else if (reg_addr == TCCPS_POWER_STATUS_OFS) begin
                st_next.rd_data = st_reg.power_status;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg <= TCCPS_STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rd_data;
    assign reg_rvalid = st_reg.rd_valid;
    assign cc_line_status = st_reg.cc_status;
    assign power_path_status = st_reg.power_status;
    assign cc_change_irq = st_reg.cc_irq;
    assign power_change_irq = st_reg.pwr_irq;
    assign discharge_active = (st_reg.disch == TCCPS_DISCH_ACTIVE);
    assign resolved_termination = st_reg.resolved;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    cc_reserved_a: assert property (cc_line_status[7:6] == 2'h0)
        else $error("cc status reserved bits set");

    seek_bit_a: assert property (1 |=> cc_line_status[TCCPS_SEEK_BIT] == $past(ctrl.seeking_connection))
        else $error("seek bit does not follow search");

    seek_fields_a: assert property (ctrl.seeking_connection |=> cc_line_status[3:0] == 4'h0)
        else $error("line fields not blank while searching");

    vconn_fields_a: assert property ((ctrl.vconn_source_enable && !ctrl.plug_flip) |=>
        cc_line_status[3:0] == 4'h0)
        else $error("line fields not blank with vconn on cc2");

    open_line_a: assert property ((!ctrl.drp_mode && !ctrl.seeking_connection &&
        (ctrl.cc1_term == TCCPS_TERM_OPEN || ctrl.cc1_term == TCCPS_TERM_RA)) |=>
        cc_line_status[1:0] == 2'h0)
        else $error("line one field set with ra or open");

    resolve_hold_a: assert property ((!ctrl.seeking_connection && !st_reg.seek_prev) |=>
        $stable(resolved_termination))
        else $error("resolved termination moved without search end");

    cc_irq_a: assert property (!$past(rst) |-> cc_change_irq == (cc_line_status != $past(cc_line_status)))
        else $error("cc alert mismatch");

    pwr_irq_a: assert property (!$past(rst) |->
        power_change_irq == (power_path_status != $past(power_path_status)))
        else $error("power alert mismatch");

    source_bit_a: assert property (1 |=>
        power_path_status[TCCPS_SRC_BIT] == $past(power.source_path_out && power.vbus_source_enable))
        else $error("source bit wrong");

    cable_off_a: assert property (!ctrl.vconn_source_enable |=> !power_path_status[TCCPS_CABLE_BIT])
        else $error("cable power shown with vconn off");

    bus_sync_a: assert property (1 |-> ##3 power_path_status[TCCPS_BUS_BIT] == $past(sense_pin.bus_power_cmp, 3))
        else $error("bus power bit latency wrong");

    disch_end_a: assert property ((discharge_active && st_reg.sense_sync.below_safe0v_cmp) |=>
        !discharge_active)
        else $error("discharge not ended at vsafe0v");

    read_cc_a: assert property ((reg_rd && !reg_wr && reg_addr == TCCPS_CC_STATUS_OFS) |=>
        reg_rvalid && reg_rdata == $past(cc_line_status))
        else $error("cc status read wrong");

    seek_found_c: cover property (cc_line_status[TCCPS_SEEK_BIT] ##1 !cc_line_status[TCCPS_SEEK_BIT]);
    disch_done_c: cover property (discharge_active ##1 !discharge_active);
    cc_irq_c: cover property (cc_change_irq && cc_line_status[1:0] == TCCPS_SNK_3P0);
    pwr_irq_c: cover property (power_change_irq && power_path_status[TCCPS_SRC_BIT]);

endmodule // tccps_status

/* tb/tccps_host_model.sv */
// ****************************************
// Host port manager issuing register cycles
// ****************************************
module tccps_host_model (
    input wire logic sys_clk,
    output logic [7:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end

    // Idle buses get inverted values so stale data never looks valid
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge sys_clk);
        #10;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #10;
        reg_rd = 1'b0;
        reg_addr = ~a;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask

    task automatic write(input logic [7:0] a, input logic [7:0] v, output logic ok);
        @(posedge sys_clk);
        #10;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #10;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
        ok = reg_rvalid;
    endtask
endmodule // tccps_host_model

/* tb/tccps_status_tb.sv */
`define chk(what, exp, got) begin checked++; if ((exp) !== (got)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module tccps_status_tb;
    import tccps_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk, rst, discharge_start, reg_rd, reg_wr, reg_rvalid, cc_change_irq, power_change_irq;
    logic discharge_active, resolved_termination, ok, rd, res;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, cc_line_status, power_path_status, d, pcc, ppw;
    tccps_ctrl_t ctrl;
    tccps_power_t power;
    tccps_sense_t sense_pin;
    int checked = 0;
    int num_errors = 0;
    int n;

    tccps_status i_dut (.sys_clk(sys_clk), .rst(rst), .ctrl(ctrl), .power(power), .sense_pin(sense_pin),
        .discharge_start(discharge_start), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cc_line_status(cc_line_status),
        .power_path_status(power_path_status), .cc_change_irq(cc_change_irq),
        .power_change_irq(power_change_irq), .discharge_active(discharge_active),
        .resolved_termination(resolved_termination));
    tccps_host_model i_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ****************************************
    // Expected values
    // ****************************************
    function automatic logic [1:0] fld(tccps_term_t t, logic [1:0] c, logic drp, logic r);
        if (drp) return r ? c : (c == 2'h3 ? 2'h0 : c);
        if (t == TCCPS_TERM_RD) return c;
        if (t == TCCPS_TERM_RP) return c == 2'h3 ? 2'h0 : c;
        return 2'h0;
    endfunction

    function automatic logic [7:0] cc_exp(logic r);
        logic m;
        m = ctrl.seeking_connection | (ctrl.vconn_source_enable & ~ctrl.plug_flip);
        return {2'h0, ctrl.seeking_connection, r,
            m ? 2'h0 : fld(ctrl.cc2_term, sense_pin.line_two_code, ctrl.drp_mode, r),
            m ? 2'h0 : fld(ctrl.cc1_term, sense_pin.line_one_code, ctrl.drp_mode, r)};
    endfunction

    function automatic logic [7:0] pw_exp();
        return {power.accessory_attached, power.init_pending, power.high_voltage_sourcing,
            power.source_path_out & power.vbus_source_enable, power.presence_detect_enabled,
            sense_pin.bus_power_cmp, sense_pin.cable_power_cmp & ctrl.vconn_source_enable, power.sink_path_out};
    endfunction

    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #10;
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Alerts pulse exactly when a status register takes a new value
    always @(posedge sys_clk) begin
        #20;
        if (!rst) begin
            `chk("cc alert", cc_line_status != pcc, cc_change_irq)
            `chk("power alert", power_path_status != ppw, power_change_irq)
        end
        pcc = cc_line_status;
        ppw = power_path_status;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        ctrl = '0;
        power = '0;
        power.presence_detect_enabled = 1'b1;
        sense_pin = '0;
        discharge_start = 1'b0;
        res = 1'b0;
        void'($urandom(44));
        step(5);
        `chk("cc in reset", 8'h00, cc_line_status)
        `chk("power in reset", 8'h08, power_path_status)
        step(7);
        rst = 1'b0;
        step(2);
        i_host.read(TCCPS_CC_STATUS_OFS, d, ok);
        `chk("cc read", 9'h100, {ok, d})
        i_host.read(TCCPS_POWER_STATUS_OFS, d, ok);
        `chk("power read", 9'h108, {ok, d})
        i_host.write(TCCPS_POWER_STATUS_OFS, 8'hf7, ok);
        i_host.write(TCCPS_CC_STATUS_OFS, 8'hff, ok);
        `chk("write answer", 1'b0, ok)
        i_host.read(TCCPS_POWER_STATUS_OFS, d, ok);
        `chk("power after write", 9'h108, {ok, d})
        i_host.read(TCCPS_CC_STATUS_OFS, d, ok);
        `chk("cc after write", 9'h100, {ok, d})
        i_host.read(8'h1f, d, ok);
        `chk("unmapped read", 9'h100, {ok, d})
        // Power path bits under random inputs; sensed pins need the sync delay
        for (n = 0; n < 24; n++) begin
            power = tccps_power_t'(7'($urandom));
            ctrl.vconn_source_enable = $urandom;
            ctrl.plug_flip = 1'b1;
            sense_pin.bus_power_cmp = $urandom;
            sense_pin.cable_power_cmp = $urandom;
            step(4);
            `chk("power status", pw_exp(), power_path_status)
        end
        // Search, resolve, then termination held while the toggler moves on
        for (n = 0; n < 16; n++) begin
            rd = $urandom;
            ctrl.seeking_connection = 1'b1;
            step(2);
            `chk("cc seeking", cc_exp(res), cc_line_status)
            ctrl.presenting_rd = rd;
            ctrl.seeking_connection = 1'b0;
            step(3);
            res = rd;
            ctrl.presenting_rd = ~rd;
            ctrl.drp_mode = (n >= 8);
            ctrl.cc1_term = ctrl.drp_mode ? TCCPS_TERM_RP : tccps_term_t'($urandom);
            ctrl.cc2_term = ctrl.drp_mode ? TCCPS_TERM_RP : tccps_term_t'($urandom);
            ctrl.vconn_source_enable = $urandom;
            ctrl.plug_flip = $urandom;
            sense_pin.line_one_code = $urandom;
            sense_pin.line_two_code = $urandom;
            step(4);
            `chk("resolved", rd, resolved_termination)
            i_host.read(TCCPS_CC_STATUS_OFS, d, ok);
            `chk("cc status", {1'b1, cc_exp(rd)}, {ok, d})
        end
        // Discharge ends itself once VBUS falls below the safe level
        discharge_start = 1'b1;
        step(1);
        discharge_start = 1'b0;
        `chk("discharge on", 1'b1, discharge_active)
        step(4);
        sense_pin.below_safe0v_cmp = 1'b1;
        n = 0;
        while (discharge_active === 1'b1) begin
            step(1);
            n++;
            if (n > 10) begin
                num_errors++;
                conclude();
            end
        end
        `chk("discharge end delay", 3, n)
        discharge_start = 1'b1;
        step(1);
        discharge_start = 1'b0;
        step(1);
        `chk("discharge refused", 1'b0, discharge_active)
        conclude();
    end
endmodule // tccps_status_tb
